// ---- cdh_host_model.sv ----
// Host model: strobed parallel master facing the display host port
`timescale 1ns/10ps
module cdh_host_model
  import cdh_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  output logic            strobe_o,
  output cdh_req_t        req_o
);
  // ----------------------------------------------------------
  // Transfers
  // ----------------------------------------------------------
  initial begin
    strobe_o = 1'b0;
    req_o    = '0;
  end

  // Selects settle a cycle before the strobe; lines released show the inverse
  task automatic xfer(input logic sel, input logic rw, input logic [7:0] d,
                      input int hold, output logic [7:0] q);
    req_o <= '{sel, rw, (rw ? ~req_o.wdata : d)};
    @(posedge clk_i);
    strobe_o <= 1'b1;
    repeat (hold) @(posedge clk_i);
    q = rdata_i;
    strobe_o <= 1'b0;
    req_o.wdata <= ~req_o.wdata;
    @(posedge clk_i);
  endtask

  // Poll status until idle; bounded so a stuck flag cannot hang the run
  task automatic wait_idle(output bit ok);
    logic [7:0] s;
    ok = 1'b0;
    for (int i = 0; i < 20 && !ok; i++) begin
      xfer(1'b0, 1'b1, 8'h00, 3, s);
      ok = (s[BUSY_BIT] === 1'b0);
    end
  endtask
endmodule

// ---- cdh_host_port.sv ----
// Top: parallel host port of a character display controller
//
// Overview of operation
// - Register select low picks instruction register, high picks data register.
// - Both host registers are eight bits on eight parallel data lines.
// - Select low, write: byte taken as instruction, internal operation starts.
// - Select low, read: busy flag on bit 7, pointer on bits 6..0.
// - Select high, write: latch byte, then store at pointer in chosen RAM.
// - Select high, read: present RAM byte fetched into data register.
// - Instruction register is write-only; no read returns it.
// - Data register buffers bytes between host and RAM both ways.
// - Busy flag high through every internal operation; instructions refused.
// - Busy clears when the operation completes; next instruction then runs.
// - Address instruction loads pointer and records display or glyph target.
// - Pointer steps up or down by one after each data transfer.
// - Display RAM holds 128 bytes addressed by seven-bit pointer.
// - Single line: positions 1..128 map to addresses 00..7F.
// - Two lines: first owns 00..3F, second owns 40..7F.
// - Twenty-column panel: lines show 00..13 and 40..53 unshifted.
// - Shift moves start by one; right shift wraps to line top.
// - Master drives first 8 columns; slave takes rest, 40 by 2; here a slave drives 20.
// - Read/write high means read from module, low means write.
`timescale 1ns/10ps
module cdh_host_port
  import cdh_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              ce_i,
  input  wire logic              strobe_i,
  input  wire logic              reg_sel_i,
  input  wire logic              rd_wr_sel_i,
  input  wire logic [7:0]        host_bus_bit_i,
  output logic      [7:0]        host_bus_bit_o,
  output logic                   host_bus_bit_oe_o,
  input  wire logic              two_line_i,
  input  wire logic              dec_mode_i,
  input  wire logic              master_i,
  input  wire logic              shift_left_i,
  input  wire logic              shift_right_i,
  output logic                   busy_flag_o,
  output logic      [ADDR_W-1:0] line1_start_o,
  output logic      [ADDR_W-1:0] line2_start_o,
  output logic      [ADDR_W-1:0] own_cols_o
);
  // ------------------------------------------------------------
  // Strobe capture
  // ------------------------------------------------------------
  cdh_req_t   req_r;
  logic       strobe_d_r;
  logic       fall;
  cdh_state_t state_r;
  logic [3:0] cnt_r;
  logic [7:0] instruction_register_r;
  logic [7:0] data_holding_register_r;
  logic [ADDR_W-1:0] ram_pointer_r;
  logic       glyph_sel_r;
  logic [7:0] disp_rdata;
  logic [7:0] glyph_rdata;
  logic       dd_we;
  logic       cg_we;
  logic       ram_ce;

  assign fall = strobe_d_r & ~strobe_i;

  // Selects and data sampled while the strobe is high, used at its fall
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      strobe_d_r <= 1'b0;
      req_r      <= '0;
    end else if (ce_i) begin
      strobe_d_r <= strobe_i;
      if (strobe_i) begin
        req_r <= '{reg_sel: reg_sel_i, rd_wr_sel: rd_wr_sel_i,
                   wdata: host_bus_bit_i};
      end
    end
  end

  // ------------------------------------------------------------
  // Internal operation sequencer
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= ST_IDLE;
      cnt_r   <= 4'h0;
    end else if (ce_i) begin
      case (state_r)
        ST_IDLE: begin
          cnt_r <= 4'h0;
          if (fall && !(req_r.rd_wr_sel && !req_r.reg_sel)) begin
            if (!req_r.reg_sel) begin
              state_r <= ST_INSTR;
            end else if (req_r.rd_wr_sel) begin
              state_r <= ST_READ;
            end else begin
              state_r <= ST_WRITE;
            end
          end
        end
        default: begin
          if (cnt_r == OP_CNT_LAST) begin
            state_r <= ST_IDLE;
          end else begin
            cnt_r <= cnt_r + 4'h1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_flag_o <= 1'b0;
    end else if (ce_i) begin
      if (state_r == ST_IDLE) begin
        busy_flag_o <= fall && !(req_r.rd_wr_sel && !req_r.reg_sel);
      end else begin
        busy_flag_o <= cnt_r != OP_CNT_LAST;
      end
    end
  end

  // ------------------------------------------------------------
  // Instruction register and pointer
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      instruction_register_r <= 8'h00;
    end else if (ce_i && state_r == ST_IDLE && fall && !req_r.reg_sel
                 && !req_r.rd_wr_sel) begin
      instruction_register_r <= req_r.wdata;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ram_pointer_r <= ADDR_ZERO;
      glyph_sel_r   <= 1'b0;
    end else if (ce_i && cnt_r == OP_CNT_LAST) begin
      if (state_r == ST_INSTR) begin
        if (instruction_register_r[LOAD_OP_BIT]) begin
          ram_pointer_r <= instruction_register_r[ADDR_W-1:0];
          glyph_sel_r   <= 1'b0;
        end else if (instruction_register_r[GLYPH_OP_BIT]) begin
          ram_pointer_r <= {1'b0, instruction_register_r[GLYPH_AW-1:0]};
          glyph_sel_r   <= 1'b1;
        end
      end else if (state_r != ST_IDLE) begin
        // Seven-bit wrap keeps the pointer inside the 128-byte RAM
        if (dec_mode_i) begin
          ram_pointer_r <= ram_pointer_r - ADDR_ONE;
        end else begin
          ram_pointer_r <= ram_pointer_r + ADDR_ONE;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // RAMs and data holding register
  // ------------------------------------------------------------
  assign ram_ce = ce_i;
  assign dd_we  = state_r == ST_WRITE && cnt_r == 4'h0 && !glyph_sel_r;
  assign cg_we  = state_r == ST_WRITE && cnt_r == 4'h0 && glyph_sel_r;

  cdh_ram #(.DEPTH(RAM_DEPTH), .AW(ADDR_W)) u_disp_ram (
    .clk_i  (clk_i),
    .ce_i   (ram_ce),
    .we_i   (dd_we),
    .addr_i (ram_pointer_r),
    .wdata_i(data_holding_register_r),
    .rdata_o(disp_rdata)
  );

  cdh_ram #(.DEPTH(GLYPH_DEPTH), .AW(GLYPH_AW)) u_glyph_ram (
    .clk_i  (clk_i),
    .ce_i   (ram_ce),
    .we_i   (cg_we),
    .addr_i (ram_pointer_r[GLYPH_AW-1:0]),
    .wdata_i(data_holding_register_r),
    .rdata_o(glyph_rdata)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_holding_register_r <= 8'h00;
    end else if (ce_i) begin
      if (state_r == ST_IDLE && fall && req_r.reg_sel && !req_r.rd_wr_sel) begin
        data_holding_register_r <= req_r.wdata;
      end else if (state_r == ST_READ && cnt_r == 4'h1) begin
        data_holding_register_r <= glyph_sel_r ? glyph_rdata : disp_rdata;
      end
    end
  end

  // ------------------------------------------------------------
  // Bus read path
  // ------------------------------------------------------------
  // Status read has no busy gate; it is how the host polls
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      host_bus_bit_o    <= 8'h00;
      host_bus_bit_oe_o <= 1'b0;
    end else if (ce_i) begin
      host_bus_bit_oe_o <= strobe_i && rd_wr_sel_i;
      if (!reg_sel_i) begin
        host_bus_bit_o <= {busy_flag_o, ram_pointer_r};
      end else begin
        host_bus_bit_o <= data_holding_register_r;
      end
    end
  end

  // ------------------------------------------------------------
  // Display window and cascade
  // ------------------------------------------------------------
  cdh_view u_view (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .ce_i         (ce_i),
    .two_line_i   (two_line_i),
    .shift_left_i (shift_left_i),
    .shift_right_i(shift_right_i),
    .line1_start_o(line1_start_o),
    .line2_start_o(line2_start_o)
  );

  // Columns driven here; as slave it drives 20 columns, not the 32 left of a 40-column row
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      own_cols_o <= PANEL_COLS;
    end else if (ce_i) begin
      own_cols_o <= master_i ? MASTER_COLS : PANEL_COLS;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  AST_BUSY_OP: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && state_r != ST_IDLE && cnt_r != OP_CNT_LAST |=> busy_flag_o)
    else $error("busy low during operation");
  AST_BUSY_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && state_r == ST_IDLE && !fall |=> !busy_flag_o)
    else $error("busy stuck high when idle");
  AST_NO_NEW: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && state_r != ST_IDLE && !(cnt_r == OP_CNT_LAST)
    |=> $stable(instruction_register_r) || !ce_i)
    else $error("instruction taken while busy");
  AST_STEP: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && (state_r == ST_WRITE || state_r == ST_READ) && cnt_r == OP_CNT_LAST
    && !dec_mode_i |=> ram_pointer_r == $past(ram_pointer_r) + ADDR_ONE)
    else $error("pointer did not step");
  AST_LOAD: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && state_r == ST_INSTR && cnt_r == OP_CNT_LAST
    && instruction_register_r[LOAD_OP_BIT]
    |=> ram_pointer_r == $past(instruction_register_r[ADDR_W-1:0]) && !glyph_sel_r)
    else $error("address load wrong");
  AST_STATUS: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !reg_sel_i |=> host_bus_bit_o == {$past(busy_flag_o), $past(ram_pointer_r)})
    else $error("status read wrong");
  AST_OE: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !rd_wr_sel_i |=> !host_bus_bit_oe_o)
    else $error("bus driven on write");
  AST_LATCH: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && state_r == ST_IDLE && fall && req_r.reg_sel && !req_r.rd_wr_sel
    |=> data_holding_register_r == $past(req_r.wdata) && state_r == ST_WRITE)
    else $error("data not latched");
  AST_COLS: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && master_i |=> own_cols_o == MASTER_COLS)
    else $error("master columns wrong");
  AST_OE_READ: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && strobe_i && rd_wr_sel_i |=> host_bus_bit_oe_o)
    else $error("bus not driven on read");
  AST_STEP_DOWN: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && (state_r == ST_WRITE || state_r == ST_READ) && cnt_r == OP_CNT_LAST
    && dec_mode_i |=> ram_pointer_r == $past(ram_pointer_r) - ADDR_ONE)
    else $error("pointer did not step down");
  AST_GLYPH_LOAD: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && state_r == ST_INSTR && cnt_r == OP_CNT_LAST
    && !instruction_register_r[LOAD_OP_BIT] && instruction_register_r[GLYPH_OP_BIT]
    |=> glyph_sel_r && ram_pointer_r == {1'b0, $past(instruction_register_r[GLYPH_AW-1:0])})
    else $error("glyph address load wrong");
  AST_REFUSE: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && state_r != ST_IDLE && cnt_r != OP_CNT_LAST
    |=> $stable(state_r))
    else $error("operation cut short");
  AST_INSTR_START: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && state_r == ST_IDLE && fall && !req_r.reg_sel && !req_r.rd_wr_sel
    |=> busy_flag_o && state_r == ST_INSTR
        && instruction_register_r == $past(req_r.wdata))
    else $error("instruction not started");
  AST_READ_FETCH: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && state_r == ST_READ && cnt_r == 4'h1 && !glyph_sel_r
    |=> data_holding_register_r == $past(disp_rdata))
    else $error("read byte not fetched");
  AST_STATUS_NO_OP: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && state_r == ST_IDLE && fall && req_r.rd_wr_sel && !req_r.reg_sel
    |=> state_r == ST_IDLE && !busy_flag_o)
    else $error("status read started an operation");
  AST_DATA_OUT: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && reg_sel_i |=> host_bus_bit_o == $past(data_holding_register_r))
    else $error("data read wrong");
endmodule

// ---- cdh_host_port_test.sv ----
// Testbench: self-checking scenarios for the display host port
`timescale 1ns/10ps
module cdh_host_port_test
  import cdh_pkg::*;
;
  // ----------------------------------------------------------
  // Stimulus and wiring
  // ----------------------------------------------------------
  logic              clk_i    = 1'b0;
  logic              rst_i    = 1'b1;
  logic              two_line = 1'b0;
  logic              dec_mode = 1'b0;
  logic              master   = 1'b0;
  logic              sh_left  = 1'b0;
  logic              sh_right = 1'b0;
  logic              ce       = 1'b1;
  logic              oe;
  logic              oe_seen  = 1'b0;
  logic              strobe;
  cdh_req_t          req;
  logic [7:0]        rdata;
  logic              busy;
  logic [ADDR_W-1:0] line1;
  logic [ADDR_W-1:0] line2;
  logic [ADDR_W-1:0] cols;
  int                n_fail   = 0;
  int                n_checks = 0;

  always #25 clk_i = ~clk_i;

  // Sticky record that the port ever drove the bus for a read
  always @(posedge clk_i) begin
    if (!rst_i) begin
      oe_seen <= oe_seen | oe;
    end
  end

  cdh_host_port dut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .strobe_i(strobe),
    .reg_sel_i(req.reg_sel), .rd_wr_sel_i(req.rd_wr_sel),
    .host_bus_bit_i(req.wdata), .host_bus_bit_o(rdata), .host_bus_bit_oe_o(oe),
    .two_line_i(two_line), .dec_mode_i(dec_mode), .master_i(master),
    .shift_left_i(sh_left), .shift_right_i(sh_right), .busy_flag_o(busy),
    .line1_start_o(line1), .line2_start_o(line2), .own_cols_o(cols)
  );

  cdh_host_model host (
    .clk_i(clk_i), .rdata_i(rdata), .strobe_o(strobe), .req_o(req)
  );

  // ----------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Full operation: busy must rise shortly after the fall, then clear
  task automatic op(input logic sel, input logic rw, input logic [7:0] d,
                    output logic [7:0] q);
    bit ok;
    logic saw;
    host.xfer(sel, rw, d, 3, q);
    saw = 1'b0;
    repeat (3) begin
      @(posedge clk_i);
      saw = saw | busy;
    end
    check({7'h0, saw}, 8'h01);
    host.wait_idle(ok);
    if (!ok) begin
      n_fail++;
      complete_run();
    end
  endtask

  task automatic stat(input logic [7:0] exp);
    logic [7:0] q;
    host.xfer(1'b0, 1'b1, 8'h00, 3, q);
    check(q, exp);
  endtask

  task automatic pulse(input logic left, input logic [7:0] e1,
                       input logic [7:0] e2);
    sh_left  <= left;
    sh_right <= ~left;
    @(posedge clk_i);
    sh_left  <= 1'b0;
    sh_right <= 1'b0;
    repeat (2) @(posedge clk_i);
    check({1'b0, line1}, e1);
    check({1'b0, line2}, e2);
  endtask

  // ----------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------
  task automatic t_reset();
    check({7'h0, busy}, 8'h00);
    check({1'b0, line1}, 8'h00);
    check({1'b0, line2}, 8'h40);
    check({1'b0, cols}, 8'h14);
    stat(8'h00);
    check({7'h0, oe_seen}, 8'h01);
    $display("t_reset done");
  endtask

  task automatic t_write();
    logic [7:0] q;
    op(1'b0, 1'b0, 8'h93, q);
    stat(8'h13);
    op(1'b1, 1'b0, 8'ha5, q);
    stat(8'h14);
    $display("t_write done");
  endtask

  // Reads are prefetched: the first read after an address load is a dummy
  task automatic t_readback();
    logic [7:0] q;
    op(1'b0, 1'b0, 8'hbf, q);
    op(1'b1, 1'b0, 8'h11, q);
    op(1'b1, 1'b0, 8'h22, q);
    stat(8'h41);
    op(1'b0, 1'b0, 8'hbf, q);
    op(1'b1, 1'b1, 8'h00, q);
    op(1'b1, 1'b1, 8'h00, q);
    check(q, 8'h11);
    op(1'b1, 1'b1, 8'h00, q);
    check(q, 8'h22);
    stat(8'h42);
    $display("t_readback done");
  endtask

  task automatic t_dec();
    logic [7:0] q;
    dec_mode <= 1'b1;
    op(1'b0, 1'b0, 8'h85, q);
    op(1'b1, 1'b0, 8'h3c, q);
    stat(8'h04);
    dec_mode <= 1'b0;
    $display("t_dec done");
  endtask

  // Address load falls while busy: must be dropped
  task automatic t_refuse();
    logic [7:0] q;
    op(1'b0, 1'b0, 8'h90, q);
    host.xfer(1'b1, 1'b0, 8'h77, 3, q);
    host.xfer(1'b0, 1'b0, 8'h85, 1, q);
    host.xfer(1'b0, 1'b1, 8'h00, 1, q);
    check(q, 8'h90);
    repeat (8) @(posedge clk_i);
    stat(8'h11);
    op(1'b0, 1'b0, 8'h85, q);
    stat(8'h05);
    $display("t_refuse done");
  endtask

  task automatic t_glyph();
    logic [7:0] q;
    op(1'b0, 1'b0, 8'h45, q);
    stat(8'h05);
    op(1'b1, 1'b0, 8'h1f, q);
    op(1'b0, 1'b0, 8'h45, q);
    op(1'b1, 1'b1, 8'h00, q);
    op(1'b1, 1'b1, 8'h00, q);
    check(q, 8'h1f);
    $display("t_glyph done");
  endtask

  task automatic t_view();
    two_line <= 1'b1;
    pulse(1'b0, 8'h3f, 8'h7f);
    pulse(1'b1, 8'h00, 8'h40);
    pulse(1'b1, 8'h01, 8'h41);
    two_line <= 1'b0;
    pulse(1'b0, 8'h00, 8'h00);
    pulse(1'b0, 8'h7f, 8'h7f);
    master <= 1'b1;
    repeat (3) @(posedge clk_i);
    check({1'b0, cols}, 8'h08);
    master <= 1'b0;
    repeat (3) @(posedge clk_i);
    check({1'b0, cols}, 8'h14);
    $display("t_view done");
  endtask

  // Clock enable low: a shift pulse is lost and the window holds
  task automatic t_freeze();
    ce      <= 1'b0;
    sh_left <= 1'b1;
    @(posedge clk_i);
    sh_left <= 1'b0;
    repeat (2) @(posedge clk_i);
    check({1'b0, line1}, 8'h7f);
    ce <= 1'b1;
    repeat (2) @(posedge clk_i);
    check({1'b0, line1}, 8'h7f);
    $display("t_freeze done");
  endtask

  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_write();
    t_readback();
    t_dec();
    t_refuse();
    t_glyph();
    t_view();
    t_freeze();
    complete_run();
  end
endmodule

// ---- cdh_pkg.sv ----
// Package: constants and types for the character display host port
package cdh_pkg;

  localparam int unsigned DATA_W       = 8;
  localparam int unsigned ADDR_W       = 7;
  localparam int unsigned RAM_DEPTH    = 128;
  localparam int unsigned GLYPH_DEPTH  = 64;
  localparam int unsigned GLYPH_AW     = 6;
  localparam int unsigned BUSY_BIT     = 7;
  localparam int unsigned LOAD_OP_BIT  = 7;
  localparam int unsigned GLYPH_OP_BIT = 6;

  localparam logic [ADDR_W-1:0] LINE1_BASE  = 7'h00;
  localparam logic [ADDR_W-1:0] LINE1_TOP   = 7'h3f;
  localparam logic [ADDR_W-1:0] LINE2_BASE  = 7'h40;
  localparam logic [ADDR_W-1:0] LINE2_TOP   = 7'h7f;
  localparam logic [ADDR_W-1:0] SINGLE_TOP  = 7'h7f;
  localparam logic [ADDR_W-1:0] ADDR_ONE    = 7'h01;
  localparam logic [ADDR_W-1:0] ADDR_ZERO   = 7'h00;
  localparam logic [5:0]        LINE_MASK   = 6'h3f;
  localparam logic [ADDR_W-1:0] MASTER_COLS = 7'h08;
  localparam logic [ADDR_W-1:0] PANEL_COLS  = 7'h14;
  localparam logic [ADDR_W-1:0] CASCADE_COLS = 7'h28;

  // Internal operation time for one instruction or data transfer
  localparam int unsigned OP_TIME_NS  = 200;
  localparam int unsigned CLK_NS      = 50;
  localparam int unsigned OP_CYCLES   = (OP_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0]  OP_CNT_LAST = 4'(OP_CYCLES - 1);

  // Host strobe bundle
  typedef struct packed {
    logic       reg_sel;
    logic       rd_wr_sel;
    logic [7:0] wdata;
  } cdh_req_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_WRITE = 2'b01,
    ST_READ  = 2'b10,
    ST_INSTR = 2'b11
  } cdh_state_t;

endpackage

// ---- cdh_ram.sv ----
// Memory: single-port byte RAM with registered read data
`timescale 1ns/10ps
module cdh_ram
  import cdh_pkg::*;
#(
  parameter int unsigned DEPTH = 128,
  parameter int unsigned AW    = 7
) (
  input  wire logic          clk_i,
  input  wire logic          ce_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [7:0]    wdata_i,
  output logic      [7:0]    rdata_o
);
  logic [7:0] mem [DEPTH];

  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      if (we_i) begin
        mem[addr_i] <= wdata_i;
      end
      rdata_o <= mem[addr_i];
    end
  end
endmodule

// ---- cdh_view.sv ----
// Display window: start addresses for both lines under shift and mode
`timescale 1ns/10ps
module cdh_view
  import cdh_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              ce_i,
  input  wire logic              two_line_i,
  input  wire logic              shift_left_i,
  input  wire logic              shift_right_i,
  output logic      [ADDR_W-1:0] line1_start_o,
  output logic      [ADDR_W-1:0] line2_start_o
);
  logic [5:0] ofs_r;
  logic [ADDR_W-1:0] ofs7_r;

  // One offset shared by both lines; two-line wrap stays inside each line's 64 bytes, single-line wraps over all 128
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ofs_r  <= 6'h00;
      ofs7_r <= ADDR_ZERO;
    end else if (ce_i) begin
      if (shift_left_i) begin
        ofs_r  <= (ofs_r + 6'h01) & LINE_MASK;
        ofs7_r <= ofs7_r + ADDR_ONE;
      end else if (shift_right_i) begin
        ofs_r  <= (ofs_r - 6'h01) & LINE_MASK;
        ofs7_r <= ofs7_r - ADDR_ONE;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      line1_start_o <= LINE1_BASE;
      line2_start_o <= LINE2_BASE;
    end else if (ce_i) begin
      if (two_line_i) begin
        line1_start_o <= LINE1_BASE | {1'b0, ofs_r};
        line2_start_o <= LINE2_BASE | {1'b0, ofs_r};
      end else begin
        line1_start_o <= ofs7_r;
        line2_start_o <= ofs7_r;
      end
    end
  end
endmodule
